// >>> pkg/hwm_pkg.sv
// hwm_pkg: constants and types shared by the monitor register bank
// assumes a 200 MHz clock and a byte-wide register access port
package hwm_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] HWM_OFS_TEST      = 8'h15;
  localparam logic [7:0] HWM_OFS_MAKER     = 8'h3e;
  localparam logic [7:0] HWM_OFS_REVISION  = 8'h3f;
  localparam logic [7:0] HWM_OFS_CONTROL   = 8'h40;
  localparam logic [7:0] HWM_OFS_FLAGS_PRI = 8'h41;
  localparam logic [7:0] HWM_OFS_FLAGS_SEC = 8'h42;
  localparam logic [7:0] HWM_OFS_VID       = 8'h47;
  localparam logic [7:0] HWM_OFS_VID5      = 8'h49;
  // ----------------------------------------
  // reset values and field positions
  // ----------------------------------------
  localparam logic [7:0] HWM_CONTROL_RST   = 8'h08;
  localparam logic [7:0] HWM_FLAGS_RST     = 8'h00;
  localparam logic [7:0] HWM_ZERO          = 8'h00;
  localparam logic [7:0] HWM_CONTROL_WMASK = 8'hb1;
  localparam int         HWM_CTL_START     = 0;
  localparam int         HWM_CTL_PULSE     = 4;
  localparam int         HWM_CTL_SELECT    = 5;
  localparam int         HWM_CTL_INIT      = 7;
  localparam int         HWM_VID_OFFSET    = 6;
  localparam int         HWM_VID_RST_EN    = 7;
  localparam int         HWM_FLT_BIT       = 6;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int         HWM_CLOCK_MHZ     = 200;
  localparam int         HWM_PULSE_MS      = 20;
  localparam int         HWM_PULSE_CYCLES  = HWM_PULSE_MS * 1000 * 1000 / 1000 * HWM_CLOCK_MHZ;
  // ----------------------------------------
  // measurement channels: 2v5, core, 3v3, 5v, local, remote, 12v, vcc
  // ----------------------------------------
  localparam int         HWM_CHANNELS      = 8;
  typedef struct packed {
    logic       write;
    logic       pointer_only;
    logic [7:0] data;
  } hwm_access_t;
endpackage

// >>> rtl/hwm_limit_check.sv
// hwm_limit_check: one measurement compared against its high and low limit
// assumes reading and limits are stable in the same clock
`timescale 1ns/1ps
module hwm_limit_check #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] reading,
  input  wire logic [WIDTH-1:0] high_limit,
  input  wire logic [WIDTH-1:0] low_limit,
  output logic                  violation
);
  // greater-than on high, less-or-equal on low
  assign violation = (reading > high_limit) || (reading <= low_limit);
endmodule // hwm_limit_check

// >>> rtl/hwm_register_bank.sv
// hwm_register_bank: register bank of a hardware monitor
// assumes a serial protocol engine outside that delivers byte accesses
// and a measurement engine that presents readings, limits and cycle ends
// Behaviour
// - pointer byte selects target of data access
// - start bit runs monitoring, zero is standby
// - pulse bit gives 20 ms low reset
// - pulse request bit clears itself
// - bit 5 selects shared pin function
// - init bit restores control and flags, self-clears
// - primary flags read-only, voltage errors bits 0-3
// - primary bits 4,5 local, remote temperature
// - secondary flags: 12 V and supply errors
// - secondary bit 6 remote diode fault
// - voltage-id bits 0-3 show cpu inputs
// - offset routed internal only under condition
// - voltage-id bit 7 enables reset output
// - high: greater-than, low: less-or-equal
// - maker identity register returns fixed code
`timescale 1ns/1ps
module hwm_register_bank
  import hwm_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE    = 8'h5a, // arbitrary value
  parameter logic [7:0] REVISION_CODE = 8'h13, // arbitrary value
  parameter int         PULSE_CYCLES  = HWM_PULSE_CYCLES
) (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic                       access_valid,
  input  wire hwm_access_t                access,
  output logic [7:0]                      read_data,
  input  wire logic [HWM_CHANNELS*8-1:0]  readings,
  input  wire logic [HWM_CHANNELS*8-1:0]  high_limits,
  input  wire logic [HWM_CHANNELS*8-1:0]  low_limits,
  input  wire logic                       cycle_done,
  input  wire logic                       diode_fault,
  input  wire logic [3:0]                 cpu_voltage_id_bits,
  input  wire logic                       fifth_voltage_id_bit,
  output logic                            monitor_run,
  output logic                            shared_pin_function_select,
  output logic                            offset_internal,
  output logic                            reset_out_n
);
  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  initial begin
    // the pulse-low check below counts eight low cycles
    if (PULSE_CYCLES < 8) $error("pulse length must be at least eight cycles");
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  always_ff @(posedge clock) begin
    pin_meta <= {fifth_voltage_id_bit, cpu_voltage_id_bits};
    pin_sync <= pin_meta;
  end

  // ----------------------------------------
  // limit comparison per channel
  // ----------------------------------------
  logic [HWM_CHANNELS-1:0] violation;
  genvar g;
  generate
    for (g = 0; g < HWM_CHANNELS; g++) begin : g_chan
      hwm_limit_check #(.WIDTH(8)) hwm_limit_check_inst (
        .reading    (readings[g*8 +: 8]),
        .high_limit (high_limits[g*8 +: 8]),
        .low_limit  (low_limits[g*8 +: 8]),
        .violation  (violation[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [7:0]  pointer;
  logic [7:0]  control;
  logic [7:0]  flags_pri;
  logic [7:0]  flags_sec;
  logic [1:0]  vid_ctl;
  logic [7:0]  test_reg;
  logic [31:0] pulse_count;
  logic [7:0]  next_pointer;
  logic [7:0]  next_control;
  logic [7:0]  next_flags_pri;
  logic [7:0]  next_flags_sec;
  logic [1:0]  next_vid_ctl;
  logic [7:0]  next_test_reg;
  logic [31:0] next_pulse_count;
  logic [7:0]  next_read_data;
  logic        data_write;
  logic        init_req;
  logic        pulse_req;

  assign data_write = access_valid && access.write && !access.pointer_only;
  assign init_req   = data_write && pointer == HWM_OFS_CONTROL
                      && access.data[HWM_CTL_INIT];
  assign pulse_req  = data_write && pointer == HWM_OFS_CONTROL
                      && access.data[HWM_CTL_PULSE] && !access.data[HWM_CTL_INIT];

  always_comb begin
    next_pointer     = pointer;
    next_control     = control;
    next_flags_pri   = flags_pri;
    next_flags_sec   = flags_sec;
    next_vid_ctl     = vid_ctl;
    next_test_reg    = test_reg;
    next_pulse_count = pulse_count;
    if (access_valid && access.write && access.pointer_only) begin
      next_pointer = access.data;
    end
    // pulse bit never stored, so it always reads zero
    next_control[HWM_CTL_PULSE] = 1'b0;
    if (control[HWM_CTL_START] && cycle_done) begin
      // flags follow each finished cycle; standby holds them
      next_flags_pri = {2'b00, violation[5:0]};
      next_flags_sec = HWM_FLAGS_RST;
      next_flags_sec[0] = violation[6];
      next_flags_sec[1] = violation[7];
      next_flags_sec[HWM_FLT_BIT] = diode_fault;
    end
    if (data_write) begin
      unique case (pointer)
        HWM_OFS_CONTROL: begin
          // reserved bits 1,2,3,6 keep their value
          next_control = (control & ~HWM_CONTROL_WMASK)
                         | (access.data & HWM_CONTROL_WMASK
                            & ~(8'h01 << HWM_CTL_PULSE));
        end
        HWM_OFS_VID:  next_vid_ctl  = access.data[7:6];
        HWM_OFS_TEST: next_test_reg = access.data;
        default: ;
      endcase
    end
    if (init_req) begin
      // init restores defaults and clears itself in the same step
      next_control   = HWM_CONTROL_RST;
      next_flags_pri = HWM_FLAGS_RST;
      next_flags_sec = HWM_FLAGS_RST;
    end
    if (pulse_req && vid_ctl[1]) begin
      next_pulse_count = PULSE_CYCLES[31:0];
    end else if (pulse_count != 32'h0000_0000) begin
      next_pulse_count = pulse_count - 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always_comb begin
    next_read_data = read_data;
    if (access_valid && !access.write) begin
      unique case (pointer)
        HWM_OFS_MAKER:     next_read_data = MAKER_CODE;
        HWM_OFS_REVISION:  next_read_data = REVISION_CODE;
        HWM_OFS_CONTROL:   next_read_data = control;
        HWM_OFS_FLAGS_PRI: next_read_data = flags_pri;
        HWM_OFS_FLAGS_SEC: next_read_data = flags_sec;
        HWM_OFS_VID:       next_read_data = {vid_ctl, 2'b00, pin_sync[3:0]};
        HWM_OFS_VID5:      next_read_data = {7'b000_0000,
                                             pin_sync[4] & control[HWM_CTL_SELECT]};
        HWM_OFS_TEST:      next_read_data = test_reg;
        default:           next_read_data = HWM_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pointer     <= HWM_ZERO;
      control     <= HWM_CONTROL_RST;
      flags_pri   <= HWM_FLAGS_RST;
      flags_sec   <= HWM_FLAGS_RST;
      vid_ctl     <= 2'b00;
      test_reg    <= HWM_ZERO;
      pulse_count <= 32'h0000_0000;
      read_data   <= HWM_ZERO;
    end else begin
      pointer     <= next_pointer;
      control     <= next_control;
      flags_pri   <= next_flags_pri;
      flags_sec   <= next_flags_sec;
      vid_ctl     <= next_vid_ctl;
      test_reg    <= next_test_reg;
      pulse_count <= next_pulse_count;
      read_data   <= next_read_data;
    end
  end

  // ----------------------------------------
  // outputs, all registered
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      monitor_run                <= 1'b0;
      shared_pin_function_select <= 1'b0;
      offset_internal            <= 1'b0;
      reset_out_n                <= 1'b1;
    end else begin
      monitor_run                <= next_control[HWM_CTL_START];
      shared_pin_function_select <= next_control[HWM_CTL_SELECT];
      offset_internal            <= next_vid_ctl[0] && !next_vid_ctl[1]
                                    && next_test_reg[0];
      reset_out_n                <= (next_pulse_count == 32'h0000_0000);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_pulse_req;
    pulse_req && vid_ctl[1];
  endsequence
  sequence s_init_req;
    init_req;
  endsequence
  sequence s_control_write;
    data_write && pointer == HWM_OFS_CONTROL && !access.data[HWM_CTL_INIT];
  endsequence
  sequence s_control_read;
    access_valid && !access.write && pointer == HWM_OFS_CONTROL;
  endsequence
  sequence s_cycle_end;
    control[HWM_CTL_START] && cycle_done && !init_req;
  endsequence
  sequence s_read_vid;
    access_valid && !access.write && pointer == HWM_OFS_VID;
  endsequence
  sequence s_read_maker;
    access_valid && !access.write && pointer == HWM_OFS_MAKER;
  endsequence
  sequence s_read_fifth_hidden;
    access_valid && !access.write && pointer == HWM_OFS_VID5 && !control[HWM_CTL_SELECT];
  endsequence

  // low-cycle counter, so the pulse length is checked without a long repetition
  logic [31:0] low_run;
  logic [31:0] next_low_run;
  always_comb begin
    next_low_run = reset_out_n ? 32'h0000_0000 : low_run + 32'h0000_0001;
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      low_run <= 32'h0000_0000;
    end else begin
      low_run <= next_low_run;
    end
  end

  AST_POINTER_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
    access_valid && access.write && access.pointer_only |=> pointer == $past(access.data))
    else $error("pointer not loaded");
  AST_STANDBY_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    !control[HWM_CTL_START] && !init_req |=> $stable(flags_pri) && $stable(flags_sec))
    else $error("flags moved in standby");
  AST_RUN_FOLLOWS: assert property (@(posedge clock) disable iff (!rst_n)
    s_control_write |=> monitor_run == $past(access.data[HWM_CTL_START]))
    else $error("run output wrong");
  AST_PULSE_LOW: assert property (@(posedge clock) disable iff (!rst_n)
    s_pulse_req |=> (!reset_out_n) [*8])
    else $error("reset pulse too short");
  AST_NO_PULSE_DISABLED: assert property (@(posedge clock) disable iff (!rst_n)
    reset_out_n && !vid_ctl[1] |=> reset_out_n)
    else $error("reset pulse while disabled");
  AST_PULSE_SELF_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
    s_control_read |=> !read_data[HWM_CTL_PULSE])
    else $error("pulse bit reads one");
  AST_INIT_RESTORE: assert property (@(posedge clock) disable iff (!rst_n)
    s_init_req |=> control == HWM_CONTROL_RST && flags_pri == HWM_FLAGS_RST
                   && flags_sec == HWM_FLAGS_RST)
    else $error("init did not restore");
  AST_RESERVED_HELD: assert property (@(posedge clock) disable iff (!rst_n)
    ((control ^ HWM_CONTROL_RST) & ~HWM_CONTROL_WMASK) == HWM_ZERO)
    else $error("reserved control bit changed");
  AST_OFFSET_ROUTE: assert property (@(posedge clock) disable iff (!rst_n)
    offset_internal |-> !vid_ctl[1] && vid_ctl[0] && test_reg[0])
    else $error("offset routed without condition");
  AST_SELECT_FOLLOWS: assert property (@(posedge clock) disable iff (!rst_n)
    s_control_write |=> shared_pin_function_select == $past(access.data[HWM_CTL_SELECT]))
    else $error("pin select output wrong");
  AST_FLAGS_PRI_UPDATE: assert property (@(posedge clock) disable iff (!rst_n)
    s_cycle_end |=> flags_pri == {2'b00, $past(violation[5:0])})
    else $error("primary flags not updated");
  AST_FLAGS_SEC_UPDATE: assert property (@(posedge clock) disable iff (!rst_n)
    s_cycle_end |=> flags_sec[1:0] == $past(violation[7:6])
                    && flags_sec[HWM_FLT_BIT] == $past(diode_fault))
    else $error("secondary flags not updated");
  AST_VID_READ: assert property (@(posedge clock) disable iff (!rst_n)
    s_read_vid |=> read_data[3:0] == $past(pin_sync[3:0]) && read_data[7:6] == $past(vid_ctl))
    else $error("voltage id read wrong");
  AST_MAKER_CODE: assert property (@(posedge clock) disable iff (!rst_n)
    s_read_maker |=> read_data == MAKER_CODE)
    else $error("maker code read wrong");
  AST_FIFTH_ID_HIDDEN: assert property (@(posedge clock) disable iff (!rst_n)
    s_read_fifth_hidden |=> read_data == HWM_ZERO)
    else $error("fifth id shown while not selected");
  AST_POINTER_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    !(access_valid && access.write && access.pointer_only) |=> $stable(pointer))
    else $error("pointer moved without load");
  AST_PULSE_LENGTH: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(reset_out_n) |-> low_run >= PULSE_CYCLES[31:0])
    else $error("reset pulse shorter than programmed");
endmodule // hwm_register_bank

// >>> bench/hwm_host_model.sv
// hwm_host_model: byte-access host on the far side of the register bank
// assumes the bench calls xfer only from its main sequence
`timescale 1ns/1ps
module hwm_host_model
  import hwm_pkg::*;
(
  input  wire logic  clock,
  output logic       access_valid,
  output hwm_access_t access
);
  initial begin
    access_valid = 1'b0;
    access       = '0;
  end
  // ----------------------------------------
  // one byte per call, held through the taking edge
  // ----------------------------------------
  task automatic xfer(input logic wr, input logic ptr, input logic [7:0] d);
    @(negedge clock);
    access_valid = 1'b1;
    access       = '{wr, ptr, d};
    @(negedge clock);
    access_valid = 1'b0;
    access       = '{1'b0, 1'b0, ~d}; // released bus never shows a stale byte
  endtask
endmodule // hwm_host_model

// >>> bench/hwm_register_bank_tb.sv
// hwm_register_bank_tb: self-checking bench of the monitor register bank
// assumes the host model drives accesses; reads are checked from a queue
`timescale 1ns/1ps
module hwm_register_bank_tb import hwm_pkg::*; ;
  localparam int         PC = 16;
  localparam logic [7:0] MK = 8'h5a; // arbitrary value
  logic              clock, rst_n, av, cd, df, v5, run, sel, offi, rstn_o, rd_seen;
  hwm_access_t       acc;
  logic [7:0]        rdat, fl1, fl2;
  logic [3:0]        vid;
  logic [63:0]       rd_v, hi, lo;
  logic [191:0]      pool;
  logic [15:0]       seed;
  logic [7:0]        q[$];
  int                failures, cmp_count, n;
  hwm_host_model host (.clock(clock), .access_valid(av), .access(acc));
  hwm_register_bank #(.MAKER_CODE(MK), .PULSE_CYCLES(PC)) hwm_register_bank_inst (
    .clock(clock), .rst_n(rst_n), .access_valid(av), .access(acc), .read_data(rdat),
    .readings(rd_v), .high_limits(hi), .low_limits(lo), .cycle_done(cd),
    .diode_fault(df), .cpu_voltage_id_bits(vid), .fifth_voltage_id_bit(v5),
    .monitor_run(run), .shared_pin_function_select(sel), .offset_internal(offi),
    .reset_out_n(rstn_o));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, 1'b1, a);
    host.xfer(1'b1, 1'b0, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host.xfer(1'b1, 1'b1, a);
    q.push_back(e);
    host.xfer(1'b0, 1'b0, 8'h00);
  endtask
  task automatic cyc();
    @(negedge clock);
    cd = 1'b1;
    @(negedge clock);
    cd = 1'b0;
  endtask
  task automatic flags();
    fl1 = '0;
    fl2 = {1'b0, df, 6'h00};
    for (int c = 0; c < 8; c++) begin
      if (rd_v[c*8+:8] > hi[c*8+:8] || rd_v[c*8+:8] <= lo[c*8+:8]) begin
        if (c < 6) fl1[c] = 1'b1;
        else fl2[c-6] = 1'b1;
      end
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ----------------------------------------
  // clock, read watcher, watchdog
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) rd_seen <= av && !acc.write;
  always @(negedge clock) if (rd_seen) chk("read_data", rdat, q.pop_front());
  initial begin
    #100000;
    failures++;
    $display("[ERR] watchdog expected done seen hang");
    tally_and_finish();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rst_n, cd, df, failures, cmp_count} = '0;
    seed = 16'ha8de;
    vid  = seed[3:0];
    v5   = 1'b1;
    rd_v = {8{8'h40}};
    hi   = '1;
    lo   = '0; // limits set before start
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    rd(HWM_OFS_CONTROL, HWM_CONTROL_RST);
    rd(HWM_OFS_FLAGS_PRI, HWM_FLAGS_RST);
    rd(HWM_OFS_FLAGS_SEC, HWM_FLAGS_RST);
    rd(HWM_OFS_VID, {4'h0, vid});
    rd(HWM_OFS_VID5, HWM_ZERO);
    rd(HWM_OFS_MAKER, MK);
    rd(8'h50, HWM_ZERO);
    wr(HWM_OFS_FLAGS_PRI, 8'hff);
    rd(HWM_OFS_FLAGS_PRI, HWM_ZERO);
    $display("test reset done");
    wr(HWM_OFS_CONTROL, 8'h7f); // pulse asked while output disabled
    rd(HWM_OFS_CONTROL, 8'h29);
    chk("run_sel", {6'h0, run, sel}, 8'h03);
    chk("reset_out_n", {7'h0, rstn_o}, 8'h01);
    rd(HWM_OFS_VID5, {7'h0, v5});
    for (int i = 0; i < 8; i++) begin
      for (int c = 0; c < 12; c++) begin
        seed = lfsr(seed);
        pool[c*16+:16] = seed;
      end
      {lo, hi, rd_v} = pool;
      if (i == 2) hi = rd_v;
      if (i == 3) lo = rd_v;
      df = seed[0];
      cyc();
      flags();
      rd(HWM_OFS_FLAGS_PRI, fl1);
      rd(HWM_OFS_FLAGS_SEC, fl2);
    end
    $display("test flags done");
    wr(HWM_OFS_CONTROL, 8'h20);
    rd_v = ~rd_v;
    df   = ~df;
    cyc();
    chk("run_sel", {6'h0, run, sel}, 8'h01);
    rd(HWM_OFS_FLAGS_PRI, fl1);
    rd(HWM_OFS_FLAGS_SEC, fl2);
    wr(HWM_OFS_VID, 8'h80);
    rd(HWM_OFS_VID, {4'h8, vid});
    wr(HWM_OFS_CONTROL, 8'h10);
    n = 0;
    repeat (PC + 8) begin
      if (rstn_o === 1'b0) n++;
      @(negedge clock);
    end
    chk("pulse_len", n[7:0], PC[7:0]);
    rd(HWM_OFS_CONTROL, HWM_CONTROL_RST);
    $display("test pulse done");
    wr(HWM_OFS_TEST, 8'h01);
    wr(HWM_OFS_VID, 8'h40);
    @(negedge clock);
    chk("offset_internal", {7'h0, offi}, 8'h01);
    wr(HWM_OFS_VID, 8'hc0);
    @(negedge clock);
    chk("offset_internal", {7'h0, offi}, 8'h00);
    wr(HWM_OFS_TEST, 8'h00);
    wr(HWM_OFS_VID, 8'h40);
    @(negedge clock);
    chk("offset_internal", {7'h0, offi}, 8'h00);
    wr(HWM_OFS_CONTROL, 8'hff);
    rd(HWM_OFS_CONTROL, HWM_CONTROL_RST);
    rd(HWM_OFS_FLAGS_PRI, HWM_ZERO);
    $display("test init done");
    rst_n = 1'b0;
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    rd(HWM_OFS_VID, {4'h0, vid});
    chk("run_sel", {6'h0, run, sel}, 8'h00);
    $display("test mid reset done");
    tally_and_finish();
  end
endmodule // hwm_register_bank_tb
